//--- rtl/tx_shaper_pkg.sv
// Constants, types and the reference pulse table for the transmit encoder and wave shaper.
package tx_shaper_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] ADDR_GLOBAL_CONFIG = 8'h02;
	localparam logic [7:0] ADDR_TX_SYS_IF_CONFIG = 8'h05;
	localparam logic [7:0] ADDR_TX_TEMPLATE_SELECT = 8'h06;
	localparam logic [7:0] ADDR_TX_AMPLITUDE_TRIM = 8'h07;
	localparam logic [7:0] ADDR_TX_WAVE_RAM_CONTROL = 8'h08;
	localparam logic [7:0] ADDR_TX_WAVE_RAM_DATA = 8'h09;
	localparam logic [7:0] ADDR_IRQ_MASK_1 = 8'h15;
	localparam logic [7:0] ADDR_IRQ_STATUS_1 = 8'h1a;

	// ==========================================================
	// Field positions
	localparam int STD_BIT = 0;
	localparam int CODE_SEL_BIT = 0;
	localparam int RAIL_SEL_BIT = 1;
	localparam int POL_INV_BIT = 2;
	localparam int EDGE_SEL_BIT = 3;
	localparam int RAM_RW_BIT = 6;
	localparam int RAM_DONE_BIT = 7;
	localparam int OVF_BIT = 0;
	localparam int CLK_LOSS_BIT = 1;

	// ==========================================================
	// Reset values and codes
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [3:0] TEMPLATE_RESET = 4'h0;
	localparam logic [5:0] TRIM_RESET = 6'h21;
	localparam logic [3:0] TEMPLATE_E1_75 = 4'h0;
	localparam logic [3:0] TEMPLATE_E1_120 = 4'h1;
	localparam logic [1:0] TEMPLATE_ARB = 2'h3;
	localparam logic [1:0] HW_CONTROL = 2'h0;
	localparam logic [3:0] LAST_SUBPHASE = 4'hf;
	localparam int AMP_LIMIT = 63;

	// ==========================================================
	// Timing
	localparam int TX_SYS_CLOCK_LOSS_CYCLES = 70;
	localparam int SUBPHASE_CYCLES = 3;

	typedef enum logic [1:0] {SLOT_ZERO, SLOT_MARK, SLOT_VIOL, SLOT_BAL} slot_t;

	// ==========================================================
	// Reference templates, signed magnitude, bit 6 is the sign.
	// Entries not filled here read as zero amplitude.
	function automatic logic [6:0] wave_rom(input logic [2:0] tsel, input logic [1:0] ui,
		input logic [3:0] sub);
		logic [6:0] v;
		v = 7'h00;
		case (tsel)
			3'h0: begin
				if (ui == 2'h0 && sub == 4'h3) v = 7'h0c;
				if (ui == 2'h0 && sub >= 4'h4 && sub <= 4'hb) v = 7'h30;
			end
			3'h1: begin
				if (ui == 2'h0 && sub == 4'h3) v = 7'h0f;
				if (ui == 2'h0 && sub >= 4'h4 && sub <= 4'hb) v = 7'h3c;
			end
			3'h4: begin
				if (ui == 2'h0) begin
					case (sub)
						4'h0: v = 7'h1f;
						4'h1: v = 7'h34;
						4'h2: v = 7'h2f;
						4'h3: v = 7'h2c;
						4'h4: v = 7'h2b;
						4'h5: v = 7'h2a;
						4'h6: v = 7'h29;
						4'h7: v = 7'h28;
						default: v = 7'h00;
					endcase
				end
				if (ui == 2'h1 && sub == 4'h0) v = 7'h43;
				if (ui == 2'h1 && sub == 4'h1) v = 7'h42;
				if (ui == 2'h1 && sub == 4'h2) v = 7'h41;
			end
			default: v = 7'h00;
		endcase
		return v;
	endfunction : wave_rom

endpackage : tx_shaper_pkg

//--- rtl/tx_line_encoder_wave_shaper.sv
// Transmit line encoder and pulse wave shaper with its register file.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Summary of operation
// - Line standard bit: 0 E1, 1 T1/J1.
// - Transmit clock missing over 70 cycles interrupts.
// - Rails sampled on software-chosen clock edge.
// - Rail polarity follows software invert bit.
// - Hardware mode: falling edge, active high.
// - Rail select: single rail or dual rail.
// - Single rail: B8ZS/HDB3 or AMI encoding.
// - Dual rail bypasses the line encoder.
// - Dual rail: P gives negative, N positive.
// - Hardware template pins pick standard, template.
// - Five T1 preset templates by cable grade.
// - Template code 11xx selects arbitrary waveform.
// - Wave RAM: 4 intervals by 16 subphases.
// - Samples are seven-bit signed magnitude, +-63.
// - Eight reference templates held in ROM.
// - Trim field scales arbitrary waveform amplitude.
// - Amplitude overflow latched, interrupts when enabled.
// - Preset templates ignore amplitude trim.
// - Trim defaults to 100001, 3 percent steps.
// - Interface select 00 means hardware pin control.
module tx_line_encoder_wave_shaper
	import tx_shaper_pkg::*;
#(
	parameter int SUBPHASE_DIV = tx_shaper_pkg::SUBPHASE_CYCLES
) (
	// Main clock and control
	input wire logic clock,
	input wire logic rst_b,
	input wire logic clk_en,
	// Hardware control pins
	input wire logic [1:0] control_if_select,
	input wire logic [3:0] template_pins,
	input wire logic [1:0] path_mode_pins,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// System transmit link
	input wire logic tx_sys_clock,
	input wire logic tx_pos_rail,
	input wire logic tx_neg_rail,
	// Line side
	output logic tx_line_pos,
	output logic tx_line_neg,
	output logic [6:0] tx_line_amp,
	output logic irq_b
);
	import tx_shaper_pkg::*;

	// ==========================================================
	// Registers
	logic [7:0] global_config_reg;
	logic [7:0] tx_sys_if_config_reg;
	logic [3:0] template_reg;
	logic [5:0] trim_reg;
	logic [7:0] ram_ctrl_reg;
	logic [6:0] ram_data_reg;
	logic [7:0] irq_mask_reg;
	logic [7:0] irq_status_reg;
	logic [6:0] wave_ram [64];
	logic [7:0] pin_s1_reg;
	logic [7:0] pin_s2_reg;
	logic [4:0] eff_cfg_reg;
	logic [2:0] tgl_sync_reg;
	logic [6:0] loss_cnt_reg;
	logic [1:0] hist_reg [4];
	logic [3:0] sub_reg;
	logic [7:0] div_reg;
	logic [6:0] amp_reg;
	logic line_pos_reg;
	logic line_neg_reg;
	logic [7:0] rdata_reg;

	logic hw_mode;
	logic [3:0] tmpl;
	logic arb_mode;
	logic [4:0] eff_cfg_next;
	logic tgl_edge;
	logic loss_evt;
	logic ovf_evt;
	logic wr_hit_status;
	logic signed [15:0] sum;
	logic signed [15:0] scaled;
	logic signed [15:0] samp;
	logic [6:0] raw;
	logic [6:0] amp_next;
	logic [5:0] ram_idx;

	// ==========================================================
	// Pin synchronisers and effective configuration
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			pin_s1_reg <= 8'h00;
			pin_s2_reg <= 8'h00;
		end else if (clk_en) begin
			pin_s1_reg <= {control_if_select, template_pins, path_mode_pins};
			pin_s2_reg <= pin_s1_reg;
		end
	end

	always_comb begin
		hw_mode = (pin_s2_reg[7:6] == HW_CONTROL);
		tmpl = hw_mode ? pin_s2_reg[5:2] : template_reg;
		arb_mode = (tmpl[3:2] == TEMPLATE_ARB);
		eff_cfg_next[0] = hw_mode ? pin_s2_reg[0] : tx_sys_if_config_reg[CODE_SEL_BIT];
		eff_cfg_next[1] = hw_mode ? pin_s2_reg[1] : tx_sys_if_config_reg[RAIL_SEL_BIT];
		eff_cfg_next[2] = hw_mode ? 1'b0 : tx_sys_if_config_reg[POL_INV_BIT];
		eff_cfg_next[3] = hw_mode ? 1'b1 : tx_sys_if_config_reg[EDGE_SEL_BIT];
		eff_cfg_next[4] = hw_mode ? (tmpl != TEMPLATE_E1_75 && tmpl != TEMPLATE_E1_120)
			: global_config_reg[STD_BIT];
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			eff_cfg_reg <= 5'h00;
		end else if (clk_en) begin
			eff_cfg_reg <= eff_cfg_next;
		end
	end

	// ==========================================================
	// Link domain: sampling and line encoding
	// Configuration is quasi-static, so each bit crosses through its own pair of flops.
	logic [1:0] lrst_reg;
	logic [4:0] lcfg_s1_reg;
	logic [4:0] lcfg_reg;
	logic rise_p_reg;
	logic rise_n_reg;
	logic fall_p_reg;
	logic fall_n_reg;
	slot_t slots_reg [8];
	slot_t slots_next [8];
	logic enc_pol_reg;
	logic enc_pol_next;
	logic enc_par_reg;
	logic enc_par_next;
	logic [1:0] lsym_reg;
	logic ltgl_reg;
	logic lin_p;
	logic lin_n;
	logic out_p;
	logic out_n;
	logic zeros8;
	logic zeros4;

	always_ff @(posedge tx_sys_clock) begin
		lrst_reg <= {lrst_reg[0], rst_b};
		lcfg_s1_reg <= eff_cfg_reg;
		lcfg_reg <= lcfg_s1_reg;
		rise_p_reg <= tx_pos_rail;
		rise_n_reg <= tx_neg_rail;
	end

	always_ff @(negedge tx_sys_clock) begin
		fall_p_reg <= tx_pos_rail;
		fall_n_reg <= tx_neg_rail;
	end

	always_comb begin
		lin_p = (lcfg_reg[3] ? fall_p_reg : rise_p_reg) ^ lcfg_reg[2];
		lin_n = (lcfg_reg[3] ? fall_n_reg : rise_n_reg) ^ lcfg_reg[2];
		enc_pol_next = enc_pol_reg;
		enc_par_next = enc_par_reg;
		out_p = 1'b0;
		out_n = 1'b0;
		case (slots_reg[7])
			SLOT_MARK, SLOT_BAL: begin
				enc_pol_next = ~enc_pol_reg;
				enc_par_next = ~enc_par_reg;
				out_p = ~enc_pol_reg;
				out_n = enc_pol_reg;
			end
			SLOT_VIOL: begin
				enc_par_next = 1'b0;
				out_p = enc_pol_reg;
				out_n = ~enc_pol_reg;
			end
			default: begin
			end
		endcase
		slots_next[0] = lin_p ? SLOT_MARK : SLOT_ZERO;
		for (int i = 1; i < 8; i++) begin
			slots_next[i] = slots_reg[i - 1];
		end
		zeros8 = 1'b1;
		zeros4 = 1'b1;
		for (int i = 0; i < 8; i++) begin
			if (slots_next[i] != SLOT_ZERO) begin
				zeros8 = 1'b0;
				if (i >= 4) zeros4 = 1'b0;
			end
		end
		if (lcfg_reg[0] && lcfg_reg[4] && zeros8) begin
			slots_next[4] = SLOT_VIOL;
			slots_next[3] = SLOT_BAL;
			slots_next[1] = SLOT_VIOL;
			slots_next[0] = SLOT_BAL;
		end else if (lcfg_reg[0] && !lcfg_reg[4] && zeros4) begin
			slots_next[4] = SLOT_VIOL;
			if (!enc_par_next) slots_next[7] = SLOT_BAL;
		end
	end

	always_ff @(posedge tx_sys_clock) begin
		if (!lrst_reg[1]) begin
			for (int i = 0; i < 8; i++) slots_reg[i] <= SLOT_ZERO;
			enc_pol_reg <= 1'b0;
			enc_par_reg <= 1'b0;
			lsym_reg <= 2'h0;
			ltgl_reg <= 1'b0;
		end else begin
			slots_reg <= slots_next;
			enc_pol_reg <= enc_pol_next;
			enc_par_reg <= enc_par_next;
			ltgl_reg <= ~ltgl_reg;
			if (lcfg_reg[1]) begin
				lsym_reg <= {lin_n & ~lin_p, lin_p & ~lin_n};
			end else begin
				lsym_reg <= {out_p, out_n};
			end
		end
	end

	// ==========================================================
	// Symbol crossing and clock loss watch
	// The symbol word is held a whole interval, so the toggle handshake lets it be sampled safely.
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			tgl_sync_reg <= 3'h0;
		end else if (clk_en) begin
			tgl_sync_reg <= {tgl_sync_reg[1:0], ltgl_reg};
		end
	end

	assign tgl_edge = tgl_sync_reg[2] ^ tgl_sync_reg[1];
	assign loss_evt = !tgl_edge && (loss_cnt_reg == 7'(TX_SYS_CLOCK_LOSS_CYCLES));

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			loss_cnt_reg <= 7'h00;
		end else if (clk_en) begin
			if (tgl_edge) begin
				loss_cnt_reg <= 7'h00;
			end else if (loss_cnt_reg <= 7'(TX_SYS_CLOCK_LOSS_CYCLES)) begin
				loss_cnt_reg <= loss_cnt_reg + 7'h01;
			end
		end
	end

	// ==========================================================
	// Pulse shaper
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			for (int k = 0; k < 4; k++) hist_reg[k] <= 2'h0;
			sub_reg <= 4'h0;
			div_reg <= 8'h00;
		end else if (clk_en) begin
			if (tgl_edge) begin
				hist_reg[0] <= lsym_reg;
				for (int k = 1; k < 4; k++) hist_reg[k] <= hist_reg[k - 1];
				sub_reg <= 4'h0;
				div_reg <= 8'h00;
			end else if (div_reg == 8'(SUBPHASE_DIV - 1)) begin
				div_reg <= 8'h00;
				if (sub_reg != LAST_SUBPHASE) sub_reg <= sub_reg + 4'h1;
			end else begin
				div_reg <= div_reg + 8'h01;
			end
		end
	end

	// Earlier pulses still ringing are summed in, which is how overlap can overflow.
	always_comb begin
		sum = 16'sh0000;
		for (int k = 0; k < 4; k++) begin
			raw = arb_mode ? wave_ram[{2'(k), sub_reg}] : wave_rom(tmpl[2:0], 2'(k), sub_reg);
			samp = raw[6] ? -$signed({10'h000, raw[5:0]}) : $signed({10'h000, raw[5:0]});
			if (hist_reg[k][1]) sum = sum + samp;
			if (hist_reg[k][0]) sum = sum - samp;
		end
		scaled = arb_mode ? 16'((sum * $signed({10'h000, trim_reg})) / $signed({10'h000, TRIM_RESET})) : sum;
		ovf_evt = arb_mode && (scaled > 16'(AMP_LIMIT) || scaled < -16'(AMP_LIMIT));
		if (scaled > 16'(AMP_LIMIT)) begin
			amp_next = {1'b0, 6'(AMP_LIMIT)};
		end else if (scaled < -16'(AMP_LIMIT)) begin
			amp_next = {1'b1, 6'(AMP_LIMIT)};
		end else if (scaled < 16'sh0000) begin
			amp_next = {1'b1, 6'(-scaled)};
		end else begin
			amp_next = {1'b0, 6'(scaled)};
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			amp_reg <= 7'h00;
			line_pos_reg <= 1'b0;
			line_neg_reg <= 1'b0;
		end else if (clk_en) begin
			amp_reg <= amp_next;
			line_pos_reg <= hist_reg[0][1];
			line_neg_reg <= hist_reg[0][0];
		end
	end

	// ==========================================================
	// Register file
	assign ram_idx = {ram_ctrl_reg[5:4], ram_ctrl_reg[3:0]};
	assign wr_hit_status = reg_rd && (reg_addr == ADDR_IRQ_STATUS_1);

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			global_config_reg <= CFG_RESET;
			tx_sys_if_config_reg <= CFG_RESET;
			template_reg <= TEMPLATE_RESET;
			trim_reg <= TRIM_RESET;
			irq_mask_reg <= CFG_RESET;
		end else if (clk_en && reg_wr) begin
			case (reg_addr)
				ADDR_GLOBAL_CONFIG: global_config_reg <= reg_wdata;
				ADDR_TX_SYS_IF_CONFIG: tx_sys_if_config_reg <= reg_wdata;
				ADDR_TX_TEMPLATE_SELECT: template_reg <= reg_wdata[3:0];
				ADDR_TX_AMPLITUDE_TRIM: trim_reg <= reg_wdata[5:0];
				ADDR_IRQ_MASK_1: irq_mask_reg <= reg_wdata;
				default: begin
				end
			endcase
		end
	end

	// A trigger is served in the cycle after it is written and the trigger bit then drops.
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			ram_ctrl_reg <= CFG_RESET;
			ram_data_reg <= 7'h00;
		end else if (clk_en) begin
			if (ram_ctrl_reg[RAM_DONE_BIT]) begin
				ram_ctrl_reg[RAM_DONE_BIT] <= 1'b0;
				if (ram_ctrl_reg[RAM_RW_BIT]) ram_data_reg <= wave_ram[ram_idx];
			end
			if (reg_wr && reg_addr == ADDR_TX_WAVE_RAM_CONTROL) ram_ctrl_reg <= reg_wdata;
			if (reg_wr && reg_addr == ADDR_TX_WAVE_RAM_DATA) ram_data_reg <= reg_wdata[6:0];
		end
	end

	always_ff @(posedge clock) begin
		if (clk_en && ram_ctrl_reg[RAM_DONE_BIT] && !ram_ctrl_reg[RAM_RW_BIT]) begin
			wave_ram[ram_idx] <= ram_data_reg;
		end
	end

	// Reading the status clears it, but an event in that same cycle stays set.
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			irq_status_reg <= 8'h00;
		end else if (clk_en) begin
			if (wr_hit_status) irq_status_reg <= 8'h00;
			if (ovf_evt) irq_status_reg[OVF_BIT] <= 1'b1;
			if (loss_evt) irq_status_reg[CLK_LOSS_BIT] <= 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			rdata_reg <= 8'h00;
		end else if (clk_en && reg_rd) begin
			case (reg_addr)
				ADDR_GLOBAL_CONFIG: rdata_reg <= global_config_reg;
				ADDR_TX_SYS_IF_CONFIG: rdata_reg <= tx_sys_if_config_reg;
				ADDR_TX_TEMPLATE_SELECT: rdata_reg <= {4'h0, template_reg};
				ADDR_TX_AMPLITUDE_TRIM: rdata_reg <= {2'h0, trim_reg};
				ADDR_TX_WAVE_RAM_CONTROL: rdata_reg <= ram_ctrl_reg;
				ADDR_TX_WAVE_RAM_DATA: rdata_reg <= {1'b0, ram_data_reg};
				ADDR_IRQ_MASK_1: rdata_reg <= irq_mask_reg;
				ADDR_IRQ_STATUS_1: rdata_reg <= irq_status_reg;
				default: rdata_reg <= 8'h00;
			endcase
		end
	end

	// ==========================================================
	// Outputs
	assign reg_rdata = rdata_reg;
	assign tx_line_pos = line_pos_reg;
	assign tx_line_neg = line_neg_reg;
	assign tx_line_amp = amp_reg;
	assign irq_b = ~|(irq_status_reg & irq_mask_reg);

endmodule : tx_line_encoder_wave_shaper
`default_nettype wire

//--- test/tx_framer_model.sv
// Framer-side model that drives the transmit link clock and rails.
`timescale 1ns/1ps
`default_nettype none
module tx_framer_model (
	// Bench control
	input wire logic run,
	input wire logic fall_edge,
	input wire logic p_bit,
	input wire logic n_bit,
	// Link
	output logic tx_sys_clock,
	output logic tx_pos_rail,
	output logic tx_neg_rail
);
	initial begin
		tx_sys_clock = 1'b0;
		tx_pos_rail = 1'b0;
		tx_neg_rail = 1'b0;
	end
	// The clock parks low while run is low; that is how a lost clock is shown.
	always begin
		#3;
		tx_sys_clock = run ? ~tx_sys_clock : 1'b0;
	end
	// Rails move on the unsampled edge, giving half a period of setup and hold.
	always @(tx_sys_clock) begin
		if (tx_sys_clock == fall_edge) begin
			tx_pos_rail <= p_bit;
			tx_neg_rail <= n_bit;
		end
	end
endmodule : tx_framer_model
`default_nettype wire

//--- test/tx_line_encoder_wave_shaper_chk.sv
// Concurrent checks on the ports of the transmit encoder and wave shaper.
`timescale 1ns/1ps
`default_nettype none
module tx_shaper_chk
	import tx_shaper_pkg::*;
(
	// Clock and control
	input wire logic clock,
	input wire logic rst_b,
	input wire logic clk_en,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// Line side
	input wire logic tx_line_pos,
	input wire logic tx_line_neg,
	input wire logic irq_b
);
	// ==========================================================
	// Shadow copies of the trim and mask registers.
	logic [5:0] trim_reg;
	logic [1:0] mask_reg;
	always_ff @(posedge clock) begin
		if (clk_en && !rst_b) begin
			trim_reg <= TRIM_RESET;
			mask_reg <= 2'h0;
		end else if (clk_en && reg_wr && reg_addr == ADDR_TX_AMPLITUDE_TRIM) begin
			trim_reg <= reg_wdata[5:0];
		end else if (clk_en && reg_wr && reg_addr == ADDR_IRQ_MASK_1) begin
			mask_reg <= reg_wdata[1:0];
		end
	end
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);
	sequence rd_of(logic [7:0] a);
		clk_en && reg_rd && !reg_wr && reg_addr == a;
	endsequence
	// ==========================================================
	// Assertions
	line_exclusive_a: assert property (!(tx_line_pos && tx_line_neg))
		else $error("both line marks high");
	rdata_hold_a: assert property (!(clk_en && reg_rd) |=> $stable(reg_rdata))
		else $error("read data moved without a read");
	unmapped_zero_a: assert property (clk_en && reg_rd && !(reg_addr inside {8'h02, 8'h05, 8'h06, 8'h07,
		8'h08, 8'h09, 8'h15, 8'h1a}) |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	trim_read_a: assert property (rd_of(ADDR_TX_AMPLITUDE_TRIM) |=> reg_rdata[5:0] == trim_reg)
		else $error("trim read back wrong");
	status_irq_a: assert property (rd_of(ADDR_IRQ_STATUS_1) ##0 !irq_b |=> reg_rdata[1:0] != 2'h0)
		else $error("interrupt without status");
	mask_gate_a: assert property (mask_reg == 2'h0 |-> irq_b)
		else $error("interrupt while masked");
	state_freeze_a: assert property (!clk_en |=> $stable(tx_line_pos) && $stable(tx_line_neg) && $stable(reg_rdata))
		else $error("state moved while frozen");
	reset_quiet_a: assert property ($rose(rst_b) |-> irq_b && reg_rdata == 8'h00 && !tx_line_pos)
		else $error("outputs not quiet after reset");
	ctl_done_a: assert property (rd_of(ADDR_TX_WAVE_RAM_CONTROL) ##0 !$past(reg_wr) && !$past(reg_wr, 2)
		|=> !reg_rdata[RAM_DONE_BIT])
		else $error("trigger bit left set");
endmodule : tx_shaper_chk
bind tx_line_encoder_wave_shaper tx_shaper_chk chk_i (.clock(clock), .rst_b(rst_b), .clk_en(clk_en),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.tx_line_pos(tx_line_pos), .tx_line_neg(tx_line_neg), .irq_b(irq_b));
`default_nettype wire

//--- test/tx_line_encoder_wave_shaper_bench.sv
// Self-checking bench for the transmit encoder and wave shaper.
`timescale 1ns/1ps
`default_nettype none
module tx_line_encoder_wave_shaper_bench;
	import tx_shaper_pkg::*;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic clk_en = 1'b1;
	logic [1:0] control_if_select = 2'h1;
	logic [3:0] template_pins = 4'h0;
	logic [1:0] path_mode_pins = 2'h2;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic run = 1'b1;
	logic fall_edge = 1'b0;
	logic p_bit = 1'b0;
	logic n_bit = 1'b0;
	wire [7:0] reg_rdata;
	wire tx_sys_clock, tx_pos_rail, tx_neg_rail, tx_line_pos, tx_line_neg, irq_b;
	wire [6:0] tx_line_amp;
	int n_mismatch = 0;
	int num_checks = 0;
	int c;
	logic [7:0] r;
	always #5 clock = ~clock;
	tx_line_encoder_wave_shaper uut (.clock(clock), .rst_b(rst_b), .clk_en(clk_en),
		.control_if_select(control_if_select), .template_pins(template_pins), .path_mode_pins(path_mode_pins),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.tx_sys_clock(tx_sys_clock), .tx_pos_rail(tx_pos_rail), .tx_neg_rail(tx_neg_rail),
		.tx_line_pos(tx_line_pos), .tx_line_neg(tx_line_neg), .tx_line_amp(tx_line_amp), .irq_b(irq_b));
	tx_framer_model framer (.run(run), .fall_edge(fall_edge), .p_bit(p_bit), .n_bit(n_bit),
		.tx_sys_clock(tx_sys_clock), .tx_pos_rail(tx_pos_rail), .tx_neg_rail(tx_neg_rail));
	// ==========================================================
	// Shared tasks
	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : results
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		// The answer was launched at the previous edge and stands, so it is taken one edge later.
		@(posedge clock);
		r = reg_rdata;
	endtask : rd
	task automatic rails(input logic p, input logic n);
		@(posedge clock);
		p_bit <= p;
		n_bit <= n;
	endtask : rails
	// A bounded wait for a line symbol; running out ends the run.
	task automatic seek(input logic p, input logic n);
		num_checks++;
		repeat (300) begin
			@(negedge clock);
			if (tx_line_pos === p && tx_line_neg === n) begin
				@(posedge clock);
				return;
			end
		end
		n_mismatch++;
		$display("unexpected at %0t: got %h expected %h", $time, {tx_line_pos, tx_line_neg}, {p, n});
		results();
	endtask : seek
	task automatic marks;
		repeat (40) @(posedge clock);
		c = 0;
		repeat (60) begin
			@(negedge clock);
			if (tx_line_pos === 1'b1 || tx_line_neg === 1'b1) c++;
		end
		@(posedge clock);
	endtask : marks
	// ==========================================================
	// Scenarios
	task automatic t_regs;
		rd(ADDR_TX_AMPLITUDE_TRIM);
		chk(r, 8'h21);
		wr(ADDR_GLOBAL_CONFIG, 8'h01);
		rd(ADDR_GLOBAL_CONFIG);
		chk(r, 8'h01);
		wr(ADDR_TX_TEMPLATE_SELECT, 8'h07);
		rd(ADDR_TX_TEMPLATE_SELECT);
		chk(r, 8'h07);
		wr(ADDR_TX_TEMPLATE_SELECT, 8'h00);
		wr(8'h03, 8'hff);
		rd(8'h03);
		chk(r, 8'h00);
		wr(ADDR_IRQ_STATUS_1, 8'hff);
		rd(ADDR_IRQ_STATUS_1);
		chk(r, 8'h00);
		clk_en <= 1'b0;
		repeat (3) @(posedge clock);
		clk_en <= 1'b1;
		$display("test regs done");
	endtask : t_regs
	// Zeros on one rail: only the substituting codes put marks on the line.
	task automatic t_code;
		rails(1'b0, 1'b0);
		for (int m = 0; m < 4; m++) begin
			wr(ADDR_GLOBAL_CONFIG, {7'h00, m[1]});
			wr(ADDR_TX_SYS_IF_CONFIG, {7'h00, m[0] ^ m[1]});
			marks();
			chk({7'h00, c != 0}, {7'h00, m[0] ^ m[1]});
		end
		$display("test code done");
	endtask : t_code
	task automatic t_dual;
		wr(ADDR_TX_SYS_IF_CONFIG, 8'h02);
		rails(1'b1, 1'b0);
		seek(1'b0, 1'b1);
		rails(1'b0, 1'b1);
		seek(1'b1, 1'b0);
		rails(1'b1, 1'b1);
		marks();
		chk(c[7:0], 8'h00);
		wr(ADDR_TX_SYS_IF_CONFIG, 8'h0e);
		fall_edge <= 1'b1;
		rails(1'b1, 1'b0);
		seek(1'b1, 1'b0);
		$display("test dual done");
	endtask : t_dual
	task automatic t_hw;
		control_if_select <= 2'h0;
		template_pins <= 4'h1;
		seek(1'b0, 1'b1);
		rails(1'b0, 1'b1);
		seek(1'b1, 1'b0);
		control_if_select <= 2'h1;
		$display("test hardware done");
	endtask : t_hw
	task automatic t_loss;
		rd(ADDR_IRQ_STATUS_1);
		run <= 1'b0;
		repeat (90) @(posedge clock);
		chk({7'h00, irq_b}, 8'h01);
		rd(ADDR_IRQ_STATUS_1);
		chk(r, 8'h02);
		rd(ADDR_IRQ_STATUS_1);
		chk(r, 8'h00);
		wr(ADDR_IRQ_MASK_1, 8'h02);
		run <= 1'b1;
		repeat (20) @(posedge clock);
		run <= 1'b0;
		repeat (90) @(posedge clock);
		chk({7'h00, irq_b}, 8'h00);
		rd(ADDR_IRQ_STATUS_1);
		chk({7'h00, irq_b}, 8'h01);
		run <= 1'b1;
		$display("test clock loss done");
	endtask : t_loss
	// Trim at its top with a preset shape must not overflow; the same trim on a loud arbitrary shape must.
	task automatic t_ovf;
		wr(ADDR_GLOBAL_CONFIG, 8'h00);
		wr(ADDR_TX_AMPLITUDE_TRIM, 8'h3f);
		wr(ADDR_IRQ_MASK_1, 8'h01);
		rails(1'b0, 1'b1);
		repeat (100) @(posedge clock);
		rd(ADDR_IRQ_STATUS_1);
		chk(r, 8'h00);
		for (int i = 0; i < 64; i++) begin
			wr(ADDR_TX_WAVE_RAM_DATA, i < 32 ? 8'h3f : (i == 47 ? 8'h7f : 8'h00));
			wr(ADDR_TX_WAVE_RAM_CONTROL, {2'h2, 6'(i)});
		end
		repeat (3) @(posedge clock);
		rd(ADDR_TX_WAVE_RAM_CONTROL);
		chk(r, 8'h3f);
		wr(ADDR_TX_WAVE_RAM_CONTROL, 8'hef);
		rd(ADDR_TX_WAVE_RAM_DATA);
		chk(r, 8'h7f);
		wr(ADDR_TX_WAVE_RAM_CONTROL, 8'hff);
		rd(ADDR_TX_WAVE_RAM_DATA);
		chk(r, 8'h00);
		wr(ADDR_TX_TEMPLATE_SELECT, 8'h0c);
		for (int i = 0; i < 300 && irq_b !== 1'b0; i++) @(posedge clock);
		chk({7'h00, irq_b}, 8'h00);
		chk({1'b0, tx_line_amp}, 8'h7f);
		rd(ADDR_IRQ_STATUS_1);
		chk(r, 8'h01);
		rails(1'b0, 1'b0);
		$display("test overflow done");
	endtask : t_ovf
	initial begin
		repeat (4) @(posedge clock);
		rst_b <= 1'b1;
		t_regs();
		t_code();
		t_dual();
		t_hw();
		t_loss();
		t_ovf();
		results();
	end
endmodule : tx_line_encoder_wave_shaper_bench
`default_nettype wire
